// file: src/dwrb_cfg.svh
// constants of the dual wiper register bank: bus codes, field positions,
// reset values and counts; included by the design files and the test bench.
`ifndef DWRB_CFG_SVH
`define DWRB_CFG_SVH

// ==========================================================
// address byte: fixed upper nibble, then the four select pins
`define DWRB_ADDR_PREFIX   4'h5
// ==========================================================
// instruction byte: [7:4] opcode, [2] potentiometer, [1:0] index
`define DWRB_OP_MSB        7
`define DWRB_OP_LSB        4
`define DWRB_POT_BIT       2
`define DWRB_IDX_MSB       1
`define DWRB_OP_STEP       4'h2
`define DWRB_OP_RD_WIPER   4'h9
`define DWRB_OP_WR_WIPER   4'ha
`define DWRB_OP_RD_STORED  4'hb
`define DWRB_OP_WR_STORED  4'hc
`define DWRB_OP_TO_WIPER   4'hd
`define DWRB_OP_TO_STORED  4'he
// ==========================================================
// counts and values
`define DWRB_CNT_ZERO      4'h0
`define DWRB_BYTE_BITS     4'h8
`define DWRB_LAST_TX_BIT   4'h7
`define DWRB_WIPER_MIN     6'h00
`define DWRB_WIPER_MAX     6'h3f
`define DWRB_NV_INIT       6'h20
`define DWRB_RECALL_IDX    2'h0

`endif

// file: src/dwrb_pkg.sv
// types shared by the dual wiper register bank modules.
// assumes dwrb_cfg.svh is on the include path.
package dwrb_pkg;
   // ==========================================================
   // serial engine states, one-hot
   typedef enum logic [6:0] {
      DWRB_IDLE  = 7'h01,
      DWRB_ADDR  = 7'h02,
      DWRB_INSTR = 7'h04,
      DWRB_DATA  = 7'h08,
      DWRB_ACK   = 7'h10,
      DWRB_SEND  = 7'h20,
      DWRB_STEP  = 7'h40
   } dwrb_state_e;
endpackage

// file: src/dwrb_tap_decode.sv
// one-hot tap selector for one potentiometer chain.
// assumes the wiper code comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dwrb_cfg.svh"
module dwrb_tap_decode #(
   parameter int CODE_W = 6,
   parameter int TAPS   = 64
) (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic [CODE_W-1:0] code,
   output logic      [TAPS-1:0]   tap_sel
);
   // ==========================================================
   // registered decode: a single tap closed at any time
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tap_sel <= TAPS'(1); // low-end tap while in reset
      end else begin
         tap_sel <= TAPS'(1) << code;
      end
   end
endmodule
`default_nettype wire

// file: src/dwrb_top.sv
// dual wiper register bank: 2-wire serial slave, two wiper registers,
// eight stored settings, power-up recall and write protection.
// assumes scl, sda, write protect and address pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "dwrb_cfg.svh"
module dwrb_top
   import dwrb_pkg::*;
#(
   parameter int WIPER_W = 6,
   parameter int TAPS    = 64
) (
   input  wire logic            core_clk,
   input  wire logic            rst_b,
   input  wire logic            scl_i,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe_b,
   input  wire logic            wp_b,
   input  wire logic [3:0]      addr_sel,
   output logic [TAPS-1:0]      tap_sel0,
   output logic [TAPS-1:0]      tap_sel1
);
   // ==========================================================
   // pin synchronisers and edge detect
   logic       scl_s1, scl_s2, scl_d;
   logic       sda_s1, sda_s2, sda_d;
   logic       wp_s1, wp_ok;
   logic [3:0] addr_s1, addr_s2;

   // scl is only ever sampled, never driven
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         scl_s1  <= 1'b1;
         scl_s2  <= 1'b1;
         scl_d   <= 1'b1;
         sda_s1  <= 1'b1;
         sda_s2  <= 1'b1;
         sda_d   <= 1'b1;
         wp_s1   <= 1'b1;
         wp_ok   <= 1'b1;
         addr_s1 <= 4'h0;
         addr_s2 <= 4'h0;
      end else begin
         scl_s1  <= scl_i;
         scl_s2  <= scl_s1;
         scl_d   <= scl_s2;
         sda_s1  <= sda_i;
         sda_s2  <= sda_s1;
         sda_d   <= sda_s2;
         wp_s1   <= wp_b;
         wp_ok   <= wp_s1;
         addr_s1 <= addr_sel;
         addr_s2 <= addr_s1;
      end
   end

   logic scl_rise, scl_fall, bus_start, bus_stop;
   assign scl_rise  = scl_s2 & ~scl_d;
   assign scl_fall  = ~scl_s2 & scl_d;
   assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

   // ==========================================================
   // storage; stored cells start mid-scale and keep their value over rst_b
   logic [WIPER_W-1:0] wiper_reg [2];
   logic [WIPER_W-1:0] nv_mem [8] = '{default: `DWRB_NV_INIT};
   logic               recall_reg;
   dwrb_state_e state_reg, next_reg;
   logic [3:0]  cnt_reg;
   logic [7:0]  shift_reg, instr_reg;
   logic        ack_ok, byte_done;
   dwrb_state_e ack_next;
   // the instruction byte is live in shift_reg until it is acknowledged
   logic [7:0] cur_instr;
   logic [3:0] op;
   logic       pot;
   logic [1:0] idx;
   assign cur_instr = (state_reg == DWRB_INSTR) ? shift_reg : instr_reg;
   assign op  = cur_instr[`DWRB_OP_MSB:`DWRB_OP_LSB];
   assign pot = cur_instr[`DWRB_POT_BIT];
   assign idx = cur_instr[`DWRB_IDX_MSB:0];
   assign byte_done = scl_fall & (cnt_reg == `DWRB_BYTE_BITS);

   // ==========================================================
   // stored-setting writes, gated by write protect
   logic               nv_we;
   logic [WIPER_W-1:0] nv_wdata;
   assign nv_we = wp_ok & byte_done & (
      ((state_reg == DWRB_DATA) & (op == `DWRB_OP_WR_STORED)) |
      ((state_reg == DWRB_INSTR) & (op == `DWRB_OP_TO_STORED)));
   assign nv_wdata = (state_reg == DWRB_DATA) ? shift_reg[WIPER_W-1:0]
                                              : wiper_reg[pot];

   always_ff @(posedge core_clk) begin
      if (nv_we) begin
         nv_mem[{pot, idx}] <= nv_wdata;
      end
   end

   // ==========================================================
   // wiper updates: load, transfer in, or single step
   logic               wip_we, step_ev;
   logic [WIPER_W-1:0] wip_wdata, cur_w;
   assign step_ev = (state_reg == DWRB_STEP) & scl_rise;
   assign cur_w   = wiper_reg[pot];
   assign wip_we  = step_ev | (byte_done & (
      ((state_reg == DWRB_DATA) & (op == `DWRB_OP_WR_WIPER)) |
      ((state_reg == DWRB_INSTR) & (op == `DWRB_OP_TO_WIPER))));

   // stepping saturates at the chain ends instead of wrapping
   always_comb begin
      if (step_ev) begin
         if (sda_s2) begin
            wip_wdata = (cur_w == `DWRB_WIPER_MAX) ? cur_w
                                                   : cur_w + 6'h01;
         end else begin
            wip_wdata = (cur_w == `DWRB_WIPER_MIN) ? cur_w
                                                   : cur_w - 6'h01;
         end
      end else if (state_reg == DWRB_DATA) begin
         wip_wdata = shift_reg[WIPER_W-1:0];
      end else begin
         wip_wdata = nv_mem[{pot, idx}];
      end
   end

   // recall fires once, in the first cycle after reset release
   always_ff @(posedge core_clk) begin
      recall_reg <= !rst_b;
   end

   for (genvar p = 0; p < 2; p++) begin : g_pot
      always_ff @(posedge core_clk) begin
         if (!rst_b) begin
            wiper_reg[p] <= `DWRB_WIPER_MIN;
         end else if (recall_reg) begin
            wiper_reg[p] <= nv_mem[{1'(p), `DWRB_RECALL_IDX}];
         end else if (wip_we && pot == 1'(p)) begin
            wiper_reg[p] <= wip_wdata;
         end
      end
   end

   dwrb_tap_decode #(.CODE_W(WIPER_W), .TAPS(TAPS)) u_tap0 (
      .core_clk (core_clk), .rst_b (rst_b),
      .code     (wiper_reg[0]), .tap_sel (tap_sel0));
   dwrb_tap_decode #(.CODE_W(WIPER_W), .TAPS(TAPS)) u_tap1 (
      .core_clk (core_clk), .rst_b (rst_b),
      .code     (wiper_reg[1]), .tap_sel (tap_sel1));

   // ==========================================================
   // acknowledge decision for the byte just completed
   always_comb begin
      ack_ok   = 1'b0;
      ack_next = DWRB_IDLE;
      case (state_reg)
         DWRB_ADDR: begin
            ack_ok   = (shift_reg == {`DWRB_ADDR_PREFIX, addr_s2});
            ack_next = DWRB_INSTR;
         end
         DWRB_INSTR: begin
            ack_ok = 1'b1;
            case (op)
               `DWRB_OP_RD_WIPER, `DWRB_OP_RD_STORED: ack_next = DWRB_SEND;
               `DWRB_OP_WR_WIPER, `DWRB_OP_WR_STORED: ack_next = DWRB_DATA;
               `DWRB_OP_TO_WIPER:  ack_next = DWRB_IDLE;
               `DWRB_OP_TO_STORED: ack_ok   = wp_ok;
               `DWRB_OP_STEP:      ack_next = DWRB_STEP;
               default:            ack_ok   = 1'b0;
            endcase
         end
         // a refused protected write shows as a missing acknowledge
         DWRB_DATA: ack_ok = (op != `DWRB_OP_WR_STORED) | wp_ok;
         default: ack_ok = 1'b0;
      endcase
   end

   logic [7:0] tx_byte;
   assign tx_byte = {2'b00, (op == `DWRB_OP_RD_WIPER) ? cur_w
                                                      : nv_mem[{pot, idx}]};

   // ==========================================================
   // serial engine; sda only ever pulled low through the enable
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_reg <= DWRB_IDLE;
         next_reg  <= DWRB_IDLE;
         cnt_reg   <= `DWRB_CNT_ZERO;
         shift_reg <= 8'h00;
         instr_reg <= 8'h00;
         sda_oe_b  <= 1'b1;
      end else if (bus_stop) begin
         state_reg <= DWRB_IDLE;
         sda_oe_b  <= 1'b1;
      end else if (bus_start) begin
         state_reg <= DWRB_ADDR;
         cnt_reg   <= `DWRB_CNT_ZERO;
         sda_oe_b  <= 1'b1;
      end else begin
         case (state_reg)
            DWRB_ADDR, DWRB_INSTR, DWRB_DATA: begin
               if (scl_rise && cnt_reg != `DWRB_BYTE_BITS) begin
                  shift_reg <= {shift_reg[6:0], sda_s2};
                  cnt_reg   <= cnt_reg + 4'h1;
               end else if (byte_done) begin
                  if (ack_ok) begin
                     sda_oe_b  <= 1'b0;
                     state_reg <= DWRB_ACK;
                     next_reg  <= ack_next;
                     if (state_reg == DWRB_INSTR) begin
                        instr_reg <= shift_reg;
                     end
                  end else begin
                     state_reg <= DWRB_IDLE;
                  end
               end
            end
            DWRB_ACK: begin
               if (scl_fall) begin
                  cnt_reg   <= `DWRB_CNT_ZERO;
                  state_reg <= next_reg;
                  if (next_reg == DWRB_SEND) begin
                     shift_reg <= tx_byte;
                     sda_oe_b  <= tx_byte[7];
                  end else begin
                     sda_oe_b  <= 1'b1;
                  end
               end
            end
            DWRB_SEND: begin
               if (scl_fall) begin
                  if (cnt_reg == `DWRB_LAST_TX_BIT) begin
                     sda_oe_b  <= 1'b1;
                     state_reg <= DWRB_IDLE;
                  end else begin
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     sda_oe_b  <= shift_reg[6];
                     cnt_reg   <= cnt_reg + 4'h1;
                  end
               end
            end
            DWRB_IDLE, DWRB_STEP: state_reg <= state_reg;
            default: state_reg <= DWRB_IDLE;
         endcase
      end
   end

   // data level is always low; only the enable moves
   always_ff @(posedge core_clk) begin
      sda_o <= 1'b0;
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_addr_hit;
      state_reg == DWRB_ADDR && byte_done && ack_ok;
   endsequence
   sequence s_ack_held;
      (!sda_oe_b && state_reg == DWRB_ACK);
   endsequence

   chk_ack_after_match: assert property (
      s_addr_hit |=> s_ack_held)
      else $error("no acknowledge after address match");
   chk_addr_miss_idle: assert property (
      (state_reg == DWRB_ADDR && byte_done &&
       shift_reg != {`DWRB_ADDR_PREFIX, addr_s2}) |=>
      (state_reg == DWRB_IDLE && sda_oe_b))
      else $error("foreign address not ignored");
   chk_sda_never_high: assert property (
      sda_o == 1'b0 &&
      (sda_oe_b || state_reg == DWRB_ACK || state_reg == DWRB_SEND))
      else $error("sda driven high or out of turn");
   chk_recall_first: assert property (
      recall_reg |=> (wiper_reg[0] == nv_mem[0] && wiper_reg[1] == nv_mem[4]))
      else $error("stored setting not recalled");
   chk_wp_blocks_nv: assert property (
      (byte_done && !wp_ok && state_reg == DWRB_DATA &&
       op == `DWRB_OP_WR_STORED) |=> ($stable(nv_mem[{pot, idx}]) &&
      state_reg == DWRB_IDLE))
      else $error("protected stored write went through");
   chk_nv_write_ok: assert property (
      (byte_done && wp_ok && state_reg == DWRB_DATA &&
       op == `DWRB_OP_WR_STORED) |=>
      nv_mem[{pot, idx}] == $past(shift_reg[WIPER_W-1:0]))
      else $error("stored write lost");
   chk_step_up_one: assert property (
      (step_ev && sda_s2 && cur_w != `DWRB_WIPER_MAX) |=>
      cur_w == $past(cur_w) + 6'h01)
      else $error("wiper step up wrong");
   chk_tap_follows: assert property (
      ##1 tap_sel0 == (TAPS'(1) << $past(wiper_reg[0])) &&
      tap_sel1 == (TAPS'(1) << $past(wiper_reg[1])))
      else $error("tap select does not follow wiper");
endmodule
`default_nettype wire

// file: tb/dwrb_host_model.sv
// host side of the two-wire bus: makes scl and pulls sda low or lets go.
// assumes a pull-up on the wire outside and the 10 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module dwrb_host_model (
   input  wire logic core_clk,
   input  wire logic sda_w,
   output logic      scl,
   output logic      sda_oe_b
);
   // ==========================================================
   // bus idle: both lines released high, scl stands still
   initial begin
      scl      = 1'b1;
      sda_oe_b = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // ==========================================================
   // bit cycle of 800 ns; sda only moves while scl is low
   task automatic xbit(input logic b, output logic r);
      sda_oe_b <= b;
      tick(3);
      scl <= 1'b1;
      tick(4);
      r = sda_w; // late in the high phase, device data long settled
      scl <= 1'b0;
      tick(1);
   endtask

   task automatic start();
      sda_oe_b <= 1'b0;
      tick(4);
      scl <= 1'b0;
      tick(1);
   endtask

   task automatic stop();
      sda_oe_b <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(4);
      sda_oe_b <= 1'b1;
      tick(4);
   endtask

   // msb first; ninth bit released so the other side can ack
   task automatic xbyte(input logic [7:0] d, output logic [7:0] r,
                        output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         xbit(d[i], b);
         r[i] = b;
      end
      xbit(1'b1, b);
      ack = ~b;
   endtask

   // ==========================================================
   // step bits; ends with scl still high so no extra rise is made
   task automatic step(input logic up, input int n);
      for (int i = 0; i < n; i++) begin
         sda_oe_b <= up;
         tick(3);
         scl <= 1'b1;
         tick(4);
         if (i < n - 1) begin
            scl <= 1'b0;
            tick(1);
         end
      end
      sda_oe_b <= 1'b0; // start if sda was high, else no change
      tick(4);
      sda_oe_b <= 1'b1; // stop
      tick(4);
   endtask
endmodule
`default_nettype wire

// file: tb/test_dwrb_top.sv
// self-checking bench for the dual wiper register bank.
// assumes dwrb_cfg.svh on the include path and the host model in tb/.
`timescale 1ns/1ps
`default_nettype none
`include "dwrb_cfg.svh"
module test_dwrb_top;
   import dwrb_pkg::*;
   logic        core_clk;
   logic        rst_b;
   logic        wp_b;
   logic        sda_o;
   logic        sda_oe_b;
   logic        scl;
   logic        host_oe_b;
   wire  logic  sda_w;
   logic [3:0]  addr_sel;
   logic [63:0] tap_sel0;
   logic [63:0] tap_sel1;
   logic        ok;
   logic [7:0]  v;
   int          err_total = 0;
   int          checks_done = 0;

   // open-drain wire with pull-up: low if either side pulls
   assign sda_w = host_oe_b & (sda_oe_b | sda_o);

   dwrb_top i_dwrb_top (.core_clk(core_clk), .rst_b(rst_b), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .wp_b(wp_b),
      .addr_sel(addr_sel), .tap_sel0(tap_sel0), .tap_sel1(tap_sel1));
   dwrb_host_model i_dwrb_host_model (.core_clk(core_clk), .sda_w(sda_w),
      .scl(scl), .sda_oe_b(host_oe_b));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // ==========================================================
   // checking and closing
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // device may only ever pull the wire low
   always @(posedge core_clk) begin
      if (sda_oe_b === 1'b0)
         chk(sda_o, 64'h0);
   end

   // ==========================================================
   // bus access tasks
   task automatic head(input logic [3:0] op, input logic pot,
                       input logic [1:0] idx, output logic ok_o);
      logic [7:0] r;
      logic       a1;
      logic       a2;
      i_dwrb_host_model.start();
      i_dwrb_host_model.xbyte({`DWRB_ADDR_PREFIX, addr_sel}, r, a1);
      a2 = 1'b0;
      if (a1)
         i_dwrb_host_model.xbyte({op, 1'b0, pot, idx}, r, a2);
      ok_o = a1 & a2;
   endtask

   task automatic wr(input logic [3:0] op, input logic pot,
                     input logic [1:0] idx, input logic [7:0] d,
                     output logic ok_o);
      logic [7:0] r;
      logic       a;
      head(op, pot, idx, ok_o);
      if (ok_o && (op == `DWRB_OP_WR_WIPER || op == `DWRB_OP_WR_STORED)) begin
         i_dwrb_host_model.xbyte(d, r, a);
         ok_o = a;
      end
      i_dwrb_host_model.stop();
   endtask

   // host releases all nine bits: eight data bits and a nack
   task automatic rd(input logic [3:0] op, input logic pot,
                     input logic [1:0] idx, output logic [7:0] val);
      logic a;
      head(op, pot, idx, a);
      i_dwrb_host_model.xbyte(8'hff, val, a);
      i_dwrb_host_model.stop();
   endtask

   task automatic taps(input logic [5:0] w0, input logic [5:0] w1);
      repeat (4) @(posedge core_clk);
      chk(tap_sel0, 64'h1 << w0);
      chk(tap_sel1, 64'h1 << w1);
   endtask

   task automatic steps(input logic up, input int n);
      head(`DWRB_OP_STEP, 1'b0, 2'h0, ok);
      chk(ok, 64'h1);
      i_dwrb_host_model.step(up, n);
   endtask

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge core_clk);
   endtask

   // ==========================================================
   // watchdog, far beyond the expected few thousand cycles
   initial begin
      repeat (40000) @(posedge core_clk);
      err_total++;
      report_and_stop();
   end

   // ==========================================================
   // tests
   initial begin
      rst_b    <= 1'b0;
      wp_b     <= 1'b1;
      addr_sel <= 4'h9;
      do_reset();
      taps(`DWRB_NV_INIT, `DWRB_NV_INIT);
      $display("test power-up recall done");

      wr(`DWRB_OP_WR_WIPER, 1'b0, 2'h0, 8'hd5, ok);
      chk(ok, 64'h1);
      wr(`DWRB_OP_WR_WIPER, 1'b1, 2'h0, 8'h3f, ok);
      taps(6'h15, 6'h3f);
      rd(`DWRB_OP_RD_WIPER, 1'b0, 2'h0, v);
      chk(v, 8'h15);
      $display("test wiper write and read done");

      addr_sel <= 4'h6;
      repeat (4) @(posedge core_clk);
      i_dwrb_host_model.start();
      i_dwrb_host_model.xbyte({`DWRB_ADDR_PREFIX, 4'h9}, v, ok);
      i_dwrb_host_model.stop();
      chk(ok, 64'h0);
      rd(`DWRB_OP_RD_WIPER, 1'b1, 2'h0, v);
      chk(v, 8'h3f);
      $display("test address select done");

      wr(`DWRB_OP_WR_STORED, 1'b0, 2'h2, 8'h07, ok);
      chk(ok, 64'h1);
      rd(`DWRB_OP_RD_STORED, 1'b0, 2'h2, v);
      chk(v, 8'h07);
      wp_b <= 1'b0;
      repeat (4) @(posedge core_clk);
      wr(`DWRB_OP_WR_STORED, 1'b0, 2'h2, 8'h0a, ok);
      chk(ok, 64'h0);
      rd(`DWRB_OP_RD_STORED, 1'b0, 2'h2, v);
      chk(v, 8'h07);
      wr(`DWRB_OP_WR_WIPER, 1'b0, 2'h0, 8'h2c, ok);
      chk(ok, 64'h1);
      taps(6'h2c, 6'h3f);
      wr(`DWRB_OP_TO_STORED, 1'b0, 2'h2, 8'h00, ok);
      chk(ok, 64'h0);
      rd(`DWRB_OP_RD_STORED, 1'b0, 2'h2, v);
      chk(v, 8'h07);
      wp_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      $display("test write protect done");

      wr(`DWRB_OP_TO_WIPER, 1'b0, 2'h2, 8'h00, ok);
      chk(ok, 64'h1);
      taps(6'h07, 6'h3f);
      wr(`DWRB_OP_TO_STORED, 1'b1, 2'h0, 8'h00, ok);
      chk(ok, 64'h1);
      rd(`DWRB_OP_RD_STORED, 1'b1, 2'h0, v);
      chk(v, 8'h3f);
      $display("test transfers done");

      steps(1'b1, 3);
      taps(6'h0a, 6'h3f);
      steps(1'b0, 12);
      taps(6'h00, 6'h3f);
      steps(1'b1, 70);
      taps(6'h3f, 6'h3f);
      $display("test step mode done");

      do_reset();
      taps(`DWRB_NV_INIT, 6'h3f);
      $display("test second reset recall done");
      report_and_stop();
   end
endmodule
`default_nettype wire
